//--- sfc_defines.vh
/*
 Constants for the serial frame configuration and interrupt-enable block:
 register offsets, field positions, codes and reset values.
 Assumes inclusion by bare name from the design files of this block.
*/
`ifndef SFC_DEFINES_VH
`define SFC_DEFINES_VH

`define SFC_OFS_CONFIG     8'h04
`define SFC_OFS_IEN_SET    8'h08
`define SFC_OFS_IEN_CLR    8'h0c
`define SFC_OFS_IEN_VIEW   8'h10
`define SFC_OFS_THR_WR     8'h1c

`define SFC_CFG_RESET      32'h00000000
`define SFC_CFG_MASK       32'hb7ffffff
`define SFC_IEN_MASK       32'h001f3fff

`define SFC_F_PROTO_LO     0
`define SFC_F_CLKSRC_LO    4
`define SFC_F_CLEN_LO      6
`define SFC_F_SYNC         8
`define SFC_F_CHK_LO       9
`define SFC_F_STOP_LO      12
`define SFC_F_ROUTE_LO     14
`define SFC_F_ORDER        16
`define SFC_F_NINE         17
`define SFC_F_CLKOUT       18
`define SFC_F_OVER         19
`define SFC_F_INHIB        20
`define SFC_F_LIMIT        21
`define SFC_F_VARSYNC      22
`define SFC_F_ITER_LO      24
`define SFC_F_FILTER       28
`define SFC_F_BIPHASE      29
`define SFC_F_SHORT        31

`define SFC_PROTO_NORMAL   4'h0
`define SFC_PROTO_RS485    4'h1
`define SFC_PROTO_HWHS     4'h2
`define SFC_PROTO_MODEM    4'h3
`define SFC_PROTO_T0       4'h4
`define SFC_PROTO_T1       4'h6
`define SFC_PROTO_IRDA     4'h8

`define SFC_CLK_MASTER     2'h0
`define SFC_CLK_PRESCALED  2'h1
`define SFC_CLK_EXTERNAL   2'h3

`define SFC_ROUTE_NORMAL   2'h0
`define SFC_ROUTE_ECHO     2'h1
`define SFC_ROUTE_LOCAL    2'h2
`define SFC_ROUTE_REMOTE   2'h3

`define SFC_IEN_RETRY      10

`endif

//--- sfc_ir_filter.v
/*
 Two-of-three majority filter for the receive line.
 Assumes a one-cycle sample strobe at one sixteenth of the bit time.
*/
`timescale 1ns/1ps
`default_nettype none
module sfc_ir_filter (
  input  wire clk_sys,    // System clock.
  input  wire nrst,       // Asynchronous reset, active low.
  input  wire enable,     // Filter on.
  input  wire sample_en,  // Sixteenth-bit sample strobe.
  input  wire line_in,    // Raw receive line.
  output reg  line_out    // Filtered or raw line.
);
  reg [2:0] taps;
  wire      vote;

  assign vote = (taps[0] & taps[1]) | (taps[1] & taps[2]) | (taps[0] & taps[2]);

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      taps     <= 3'h7;
      line_out <= 1'b1;
    end else begin
      if (sample_en) begin
        taps <= {taps[1:0], line_in};
      end
      line_out <= enable ? vote : line_in;
    end
  end
endmodule
`default_nettype wire

//--- sfc_refusal_ctl.v
/*
 Smart card refusal control: decides whether a parity error earns a
 refusal and counts successive ones against the retry limit.
 Assumes one-cycle parity error and character-good pulses from the receiver.
*/
`timescale 1ns/1ps
`include "sfc_defines.vh"
`default_nettype none
module sfc_refusal_ctl (
  input  wire       clk_sys,     // System clock.
  input  wire       nrst,        // Asynchronous reset, active low.
  input  wire       smart_card,  // Smart card protocol active.
  input  wire       t0_mode,     // Protocol T=0 active.
  input  wire       inhibit,     // Refusal inhibit.
  input  wire       limit_en,    // Successive refusal limiting.
  input  wire [2:0] retry_limit, // Maximum repetitions.
  input  wire       par_err,     // Parity error pulse.
  input  wire       char_ok,     // Good character pulse.
  input  wire       limit_clr,   // Clears the reached flag.
  output reg        refuse,      // Refusal pulse on the line.
  output reg        limit_hit    // Retry limit reached flag.
);
  reg [2:0] tries;
  wire      use_limit;
  wire      at_limit;

  assign use_limit = limit_en & t0_mode;
  assign at_limit  = (tries >= retry_limit);

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tries     <= 3'h0;
      refuse    <= 1'b0;
      limit_hit <= 1'b0;
    end else begin
      refuse <= 1'b0;
      if (char_ok) begin
        tries <= 3'h0;
      end
      if (smart_card && par_err && !inhibit) begin
        if (!use_limit) begin
          refuse <= 1'b1;
        end else if (!at_limit) begin
          refuse <= 1'b1;
          tries  <= tries + 3'h1;
        end
      end
      // Set wins over clear so a hit in the clearing cycle is kept.
      if (smart_card && par_err && !inhibit && use_limit && at_limit) begin
        limit_hit <= 1'b1;
      end else if (limit_clr) begin
        limit_hit <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- sfc_top.v
/*
 Mode and format register with set, clear and view interrupt enables of a
 multi-mode serial port, plus the decode of every configuration field.
 Assumes a single-cycle register port, pins synchronous to clk_sys, and a
 transmitter and receiver outside that consume the decoded fields.
*/
`timescale 1ns/1ps
`include "sfc_defines.vh"
`default_nettype none
module sfc_top (
  input  wire        clk_sys,          // System clock, 10 MHz.
  input  wire        nrst,             // Asynchronous reset, active low.
  input  wire [7:0]  reg_addr,         // Register byte address.
  input  wire [31:0] reg_wdata,        // Write data.
  input  wire        reg_wr,           // Write strobe.
  input  wire        reg_rd,           // Read strobe.
  output reg  [31:0] reg_rdata,        // Read data, cycle after strobe.
  input  wire        tx_core_out,      // Transmitter serial output.
  input  wire        rxd_in,           // Receive pin.
  output reg         txd_out,          // Transmit pin.
  output reg         rx_core_in,       // Line into the receiver.
  output reg         tx_active,        // Transmitter may run.
  output reg         rx_active,        // Receiver may run.
  input  wire        sclk_in,          // Serial clock pin input.
  input  wire        sclk_gen,         // Internally made serial clock.
  output reg         sclk_out,         // Serial clock pin output.
  output reg         sclk_oe_n,        // Serial clock enable, low drives.
  input  wire        master_clock_in,  // Master clock tick.
  input  wire        prescaled_tick,   // Prescaled master clock tick.
  output reg         sel_clock_tick,   // Selected clock source tick.
  output reg  [3:0]  protocol,         // Decoded protocol code.
  output reg         proto_reserved,   // Protocol code reserved.
  output reg         smart_card,       // Smart card protocol active.
  output reg         irda_mode,        // Infrared protocol active.
  output reg         clk_reserved,     // Clock source code reserved.
  output reg  [3:0]  char_bits,        // Character length in bits.
  output reg         sync_mode,        // Synchronous operation.
  output reg         parity_on,        // Parity bit present.
  output reg         parity_odd,       // Odd parity.
  output reg         parity_forced,    // Parity forced to a value.
  output reg         parity_force_val, // Forced parity value.
  output reg         multidrop,        // Multidrop addressing.
  output reg  [1:0]  stop_halves,      // Stop length in half bits minus two.
  output reg         stop_reserved,    // Stop code reserved.
  output reg         msb_first,        // Most significant bit first.
  output reg         over8,            // Eight times oversampling.
  output reg         biphase_on,       // Biphase encoder and decoder on.
  output reg         one_bit_delim,    // Single-bit start delimiter.
  output reg         tx_sync_cmd,      // Next frame uses command sync.
  input  wire        sample_en,        // Sixteenth-bit sample strobe.
  input  wire        par_err,          // Receiver parity error pulse.
  input  wire        char_ok,          // Receiver good character pulse.
  input  wire        limit_clr,        // Retry flag reset command.
  output wire        refuse,           // Refusal pulse.
  output wire        limit_hit,        // Retry limit reached flag.
  output reg  [31:0] irq_enables       // Enabled interrupt sources.
);
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg  [31:0] frame_config;
  reg  [31:0] irq_en;
  reg         sync_cmd_hold;
  reg  [31:0] next_rdata;
  wire        wr_cfg;
  wire        wr_set;
  wire        wr_clr;
  wire        wr_thr;
  wire        filt_line;
  wire [3:0]  f_proto;
  wire [1:0]  f_clk;
  wire [1:0]  f_route;

  function [1:0] field2;
    input [31:0] word;
    input integer lo;
    begin
      field2 = {word[lo + 1], word[lo]};
    end
  endfunction

  assign wr_cfg  = reg_wr && (reg_addr == `SFC_OFS_CONFIG);
  assign wr_set  = reg_wr && (reg_addr == `SFC_OFS_IEN_SET);
  assign wr_clr  = reg_wr && (reg_addr == `SFC_OFS_IEN_CLR);
  assign wr_thr  = reg_wr && (reg_addr == `SFC_OFS_THR_WR);
  assign f_proto = frame_config[`SFC_F_PROTO_LO + 3:`SFC_F_PROTO_LO];
  assign f_clk   = field2(frame_config, `SFC_F_CLKSRC_LO);
  assign f_route = field2(frame_config, `SFC_F_ROUTE_LO);

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      frame_config  <= `SFC_CFG_RESET;
      irq_en        <= 32'h00000000;
      sync_cmd_hold <= 1'b0;
    end else begin
      if (wr_cfg) begin
        // Reserved bits are dropped so they always read back as zero.
        frame_config <= reg_wdata & `SFC_CFG_MASK;
      end

      // Set and clear arrive on separate strobes, so they never collide.
      if (wr_set) begin
        irq_en <= irq_en | (reg_wdata & `SFC_IEN_MASK);
      end else if (wr_clr) begin
        irq_en <= irq_en & ~(reg_wdata & `SFC_IEN_MASK);
      end

      // Holding-register writes are snooped for the sync type bit.
      if (wr_thr) begin
        sync_cmd_hold <= reg_wdata[15];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always @* begin
    next_rdata = 32'h00000000;
    case (reg_addr)
      `SFC_OFS_CONFIG: begin
        next_rdata = frame_config;
      end
      `SFC_OFS_IEN_VIEW: begin
        next_rdata = irq_en;
      end
      // Write-only and unmapped offsets read as zero.
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
    end else begin
      // Data stand one cycle only, so a stale word is never seen.
      reg_rdata <= reg_rd ? next_rdata : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      protocol         <= `SFC_PROTO_NORMAL;
      proto_reserved   <= 1'b0;
      smart_card       <= 1'b0;
      irda_mode        <= 1'b0;
      clk_reserved     <= 1'b0;
      char_bits        <= 4'h5;
      sync_mode        <= 1'b0;
      parity_on        <= 1'b1;
      parity_odd       <= 1'b0;
      parity_forced    <= 1'b0;
      parity_force_val <= 1'b0;
      multidrop        <= 1'b0;
      stop_halves      <= 2'h0;
      stop_reserved    <= 1'b0;
      msb_first        <= 1'b0;
      over8            <= 1'b0;
      biphase_on       <= 1'b0;
      one_bit_delim    <= 1'b0;
      tx_sync_cmd      <= 1'b0;
      irq_enables      <= 32'h00000000;
    end else begin
      protocol <= f_proto;
      case (f_proto)
        `SFC_PROTO_NORMAL,
        `SFC_PROTO_RS485,
        `SFC_PROTO_HWHS,
        `SFC_PROTO_MODEM,
        `SFC_PROTO_T0,
        `SFC_PROTO_T1,
        `SFC_PROTO_IRDA: begin
          proto_reserved <= 1'b0;
        end
        default: begin
          proto_reserved <= 1'b1;
        end
      endcase
      // Both smart card codes share the refusal path; only T=0 counts.
      smart_card <= (f_proto == `SFC_PROTO_T0) || (f_proto == `SFC_PROTO_T1);
      irda_mode  <= (f_proto == `SFC_PROTO_IRDA);

      clk_reserved <= (f_clk == 2'h2);

      if (frame_config[`SFC_F_NINE]) begin
        char_bits <= 4'h9;
      end else begin
        char_bits <= {2'h0, field2(frame_config, `SFC_F_CLEN_LO)} + 4'h5;
      end

      sync_mode <= frame_config[`SFC_F_SYNC];

      // Parity: bit 2 clear means a parity bit is sent.
      parity_on        <= ~frame_config[`SFC_F_CHK_LO + 2];
      parity_odd       <= (frame_config[`SFC_F_CHK_LO + 2:`SFC_F_CHK_LO] == 3'h1);
      parity_forced    <= (frame_config[`SFC_F_CHK_LO + 2:`SFC_F_CHK_LO + 1] == 2'h1);
      parity_force_val <= frame_config[`SFC_F_CHK_LO];
      multidrop <= (frame_config[`SFC_F_CHK_LO + 2:`SFC_F_CHK_LO + 1] == 2'h3);

      // Code one is legal only in asynchronous operation.
      case (field2(frame_config, `SFC_F_STOP_LO))
        2'h0: begin
          stop_halves   <= 2'h0;
          stop_reserved <= 1'b0;
        end
        2'h1: begin
          stop_halves   <= 2'h1;
          stop_reserved <= frame_config[`SFC_F_SYNC];
        end
        2'h2: begin
          stop_halves   <= 2'h2;
          stop_reserved <= 1'b0;
        end
        default: begin
          stop_halves   <= 2'h0;
          stop_reserved <= 1'b1;
        end
      endcase

      msb_first     <= frame_config[`SFC_F_ORDER];
      over8         <= frame_config[`SFC_F_OVER];
      biphase_on    <= frame_config[`SFC_F_BIPHASE];
      one_bit_delim <= frame_config[`SFC_F_SHORT];

      // Without auto update the synchronous select bit names the sync type.
      if (frame_config[`SFC_F_VARSYNC]) begin
        tx_sync_cmd <= sync_cmd_hold;
      end else begin
        tx_sync_cmd <= frame_config[`SFC_F_SYNC];
      end

      // The view copy lags the register by one cycle, like every field.
      irq_enables <= irq_en;
    end
  end

  // ----------------------------------------------------------------
  // Pin routing and loopback modes
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      txd_out        <= 1'b1;
      rx_core_in     <= 1'b1;
      tx_active      <= 1'b1;
      rx_active      <= 1'b1;
    end else begin
      // Echo takes the filtered line; remote loop bypasses the filter
      // so the far end gets its own bits back untouched.
      case (f_route)
        `SFC_ROUTE_ECHO: begin
          txd_out    <= filt_line;
          rx_core_in <= filt_line;
          tx_active  <= 1'b1;
          rx_active  <= 1'b1;
        end

        `SFC_ROUTE_LOCAL: begin
          txd_out    <= 1'b1;
          rx_core_in <= tx_core_out;
          tx_active  <= 1'b1;
          rx_active  <= 1'b1;
        end

        `SFC_ROUTE_REMOTE: begin
          txd_out    <= rxd_in;
          rx_core_in <= 1'b1;
          tx_active  <= 1'b0;
          rx_active  <= 1'b0;
        end

        default: begin
          txd_out    <= tx_core_out;
          rx_core_in <= filt_line;
          tx_active  <= 1'b1;
          rx_active  <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Serial clock pin and clock source
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sclk_out       <= 1'b0;
      sclk_oe_n      <= 1'b1;
      sel_clock_tick <= 1'b0;
    end else begin
      // The pin is never driven while it is itself the clock source.
      sclk_oe_n <= ~(frame_config[`SFC_F_CLKOUT] && (f_clk != `SFC_CLK_EXTERNAL));
      sclk_out  <= sclk_gen;

      // The reserved code gives no tick, so nothing runs from it.
      case (f_clk)
        `SFC_CLK_MASTER: begin
          sel_clock_tick <= master_clock_in;
        end
        `SFC_CLK_PRESCALED: begin
          sel_clock_tick <= prescaled_tick;
        end
        `SFC_CLK_EXTERNAL: begin
          sel_clock_tick <= sclk_in;
        end
        default: begin
          sel_clock_tick <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive filter and smart card refusal
  // ----------------------------------------------------------------
  // The taps always run, so they are settled when the filter is switched on.
  sfc_ir_filter u_filter (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .enable    (frame_config[`SFC_F_FILTER]),
    .sample_en (sample_en),
    .line_in   (rxd_in),
    .line_out  (filt_line)
  );

  // The refusal block ignores the retry limit itself outside T=0.
  sfc_refusal_ctl u_refusal (
    .clk_sys     (clk_sys),
    .nrst        (nrst),
    .smart_card  (smart_card),
    .t0_mode     (protocol == `SFC_PROTO_T0),
    .inhibit     (frame_config[`SFC_F_INHIB]),
    .limit_en    (frame_config[`SFC_F_LIMIT]),
    .retry_limit (frame_config[`SFC_F_ITER_LO + 2:`SFC_F_ITER_LO]),
    .par_err     (par_err),
    .char_ok     (char_ok),
    .limit_clr   (limit_clr),
    .refuse      (refuse),
    .limit_hit   (limit_hit)
  );
endmodule
`default_nettype wire

//--- sfc_peer.sv
/*
 Remote serial peer: drives the receive pin and watches the transmit pin.
 Assumes the bench commands each level it sends, one per clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sfc_peer (
  input  wire logic clk_sys,  // System clock.
  input  wire logic nrst,     // Reset, active low.
  input  wire logic send_bit, // Level to put on the line.
  input  wire logic txd_line, // Device transmit pin.
  output var  logic rxd_line, // Device receive pin.
  output var  logic seen_bit  // Last level seen on the transmit pin.
);
  // The line idles high, as a serial line marks between characters.
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rxd_line <= 1'b1;
      seen_bit <= 1'b1;
    end else begin
      rxd_line <= send_bit;
      seen_bit <= txd_line;
    end
  end
endmodule
`default_nettype wire

//--- sfc_chk_sva.sv
/*
 Assertions on the ports of the frame configuration block.
 Assumes it is bound onto sfc_top with every port of the same name.
*/
`timescale 1ns/1ps
`include "sfc_defines.vh"
`default_nettype none
module sfc_chk (
  input wire logic        clk_sys,    // System clock.
  input wire logic        nrst,       // Reset, active low.
  input wire logic [7:0]  reg_addr,   // Register address.
  input wire logic [31:0] reg_wdata,  // Write data.
  input wire logic        reg_wr,     // Write strobe.
  input wire logic        reg_rd,     // Read strobe.
  input wire logic [31:0] reg_rdata,  // Read data.
  input wire logic        txd_out,    // Transmit pin.
  input wire logic        sclk_oe_n,  // Clock pin enable.
  input wire logic [3:0]  char_bits,  // Character length.
  input wire logic        parity_on,  // Parity present.
  input wire logic        multidrop,  // Multidrop mode.
  input wire logic        smart_card, // Smart card protocol.
  input wire logic        par_err,    // Parity error pulse.
  input wire logic        refuse,     // Refusal pulse.
  input wire logic [31:0] irq_enables // Enabled sources.
);
  // ------
  // Shadow of the configuration and its age since the last write
  // ------
  // The age lets steady-state checks skip the cycles where decode lags.
  reg [31:0] cfg;
  reg [1:0]  age;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg <= 32'h0;
      age <= 2'h0;
    end else if (reg_wr && reg_addr == `SFC_OFS_CONFIG) begin
      cfg <= reg_wdata & `SFC_CFG_MASK;
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_wr(a);
    reg_wr && reg_addr == a;
  endsequence
  a_view_read: assert property (
    reg_rd && reg_addr == `SFC_OFS_IEN_VIEW |=> reg_rdata == irq_enables)
    else $error("view read differs from enables");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  a_set_bits: assert property (s_wr(`SFC_OFS_IEN_SET) |-> ##2
    irq_enables == ($past(irq_enables) | ($past(reg_wdata, 2) & `SFC_IEN_MASK)))
    else $error("set write wrong");
  a_clear_bits: assert property (s_wr(`SFC_OFS_IEN_CLR) |-> ##2
    irq_enables == ($past(irq_enables) & ~($past(reg_wdata, 2) & `SFC_IEN_MASK)))
    else $error("clear write wrong");
  a_char_len: assert property (s_wr(`SFC_OFS_CONFIG) |-> ##2
    char_bits == ($past(reg_wdata[17], 2) ? 4'h9 : 4'h5 + {2'h0, $past(reg_wdata[7:6], 2)}))
    else $error("character length wrong");
  a_clock_pin: assert property (s_wr(`SFC_OFS_CONFIG) |-> ##2
    sclk_oe_n == !($past(reg_wdata[18], 2) && $past(reg_wdata[5:4], 2) != 2'h3))
    else $error("clock pin drive wrong");
  a_parity_dec: assert property (age == 2'h3 |->
    (parity_on == !cfg[11]) && (multidrop == (cfg[11:10] == 2'h3)))
    else $error("parity decode wrong");
  a_local_loop: assert property (
    age == 2'h3 && cfg[15:14] == `SFC_ROUTE_LOCAL |-> txd_out)
    else $error("transmit pin not high in local loop");
  a_inhibit_quiet: assert property (age == 2'h3 && par_err && cfg[20] |=> !refuse)
    else $error("refusal while inhibited");
  a_refuse_each: assert property (
    age == 2'h3 && par_err && smart_card && !cfg[20] && !cfg[21] |=> refuse)
    else $error("parity error not refused");
  a_refuse_cause: assert property (!par_err |=> !refuse)
    else $error("refusal without parity error");
endmodule
`default_nettype wire

//--- sfc_top_bench.sv
/*
 Self-checking bench for the frame configuration block.
 Assumes the design files and sfc_peer, sfc_chk are compiled alongside.
*/
`timescale 1ns/1ps
`include "sfc_defines.vh"
`default_nettype none
module sfc_top_bench;
  logic clk_sys, nrst, reg_wr, reg_rd, tx_core_out, sample_en, par_err;
  logic char_ok, limit_clr, master_clock_in, prescaled_tick, sclk_in, sclk_gen;
  logic send_bit, lo;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, w;
  logic [3:0] v;
  wire [31:0] reg_rdata, irq_enables;
  wire [3:0] protocol, char_bits;
  wire [1:0] stop_halves;
  wire rxd_in, txd_out, rx_core_in, tx_active, rx_active, sclk_out, sclk_oe_n;
  wire sel_clock_tick, proto_reserved, smart_card, irda_mode, clk_reserved;
  wire sync_mode, parity_on, parity_odd, parity_forced, parity_force_val;
  wire multidrop, stop_reserved, msb_first, over8, biphase_on, one_bit_delim;
  wire tx_sync_cmd, refuse, limit_hit, seen_bit;
  int err_total = 0;
  int num_checks = 0;
  int cyc_cnt = 0;
  sfc_top u_dut (.*);
  sfc_peer u_peer (.clk_sys(clk_sys), .nrst(nrst), .send_bit(send_bit),
    .txd_line(txd_out), .rxd_line(rxd_in), .seen_bit(seen_bit));
  // ------
  // Helpers
  // ------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic pe(input logic e);
    @(posedge clk_sys);
    par_err <= 1'b1;
    @(posedge clk_sys);
    par_err <= 1'b0;
    #1 chk(refuse, e);
  endtask
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // The run needs well under a thousand cycles; the ceiling leaves room.
  always @(posedge clk_sys) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      err_total++;
      test_done;
    end
  end
  // ------
  // Tests
  // ------
  initial begin
    {nrst, reg_wr, reg_rd, par_err, char_ok, limit_clr, prescaled_tick} = 7'h0;
    {master_clock_in, sclk_in, sclk_gen, sample_en, send_bit, tx_core_out} = 6'h3f;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    cyc(1);
    chk(char_bits, 4'h5);
    chk({txd_out, sclk_oe_n, parity_on}, 3'h7);
    rd(`SFC_OFS_IEN_VIEW, 32'h0);
    rd(`SFC_OFS_CONFIG, `SFC_CFG_RESET);
    wr(`SFC_OFS_CONFIG, 32'hffffffff);
    wr(8'h44, 32'h0);
    rd(`SFC_OFS_CONFIG, `SFC_CFG_MASK);
    rd(`SFC_OFS_IEN_SET, 32'h0);
    rd(8'h40, 32'h0);
    $display("Test registers done");
    for (int i = 0; i < 16; i++) begin
      v = i[3:0];
      w = {v[2], 1'b0, v[1], 9'h0, v[3], 1'b1, v == 4'hf, v[0], 2'h0, v[2:1], v[3:1],
        v[0], v[3:2], v[1:0], v};
      @(posedge clk_sys);
      sclk_gen <= v[0];
      master_clock_in <= v[2];
      wr(`SFC_OFS_CONFIG, w);
      cyc(2);
      chk({proto_reserved, protocol}, {!(v inside {0, 1, 2, 3, 4, 6, 8}), v});
      chk({smart_card, irda_mode}, {v == 4'h4 || v == 4'h6, v == 4'h8});
      chk({clk_reserved, sclk_oe_n}, {v[1:0] == 2'h2, v[1:0] == 2'h3});
      chk(sel_clock_tick, v[1:0] == 2'h0 ? v[2] : v[1:0] == 2'h3);
      chk(sclk_out, v[0]);
      chk(char_bits, v == 4'hf ? 4'h9 : 4'h5 + {2'h0, v[3:2]});
      chk({sync_mode, msb_first, over8}, {v[0], v[0], v[3]});
      chk({parity_on, parity_odd}, {!v[3], v[3:1] == 3'h1});
      chk({parity_forced, multidrop}, {v[3:2] == 2'h1, v[3:2] == 2'h3});
      chk(parity_force_val, v[1]);
      lo = v[2:1] == 2'h3 || (v[2:1] == 2'h1 && v[0]);
      chk(stop_reserved, lo);
      if (!lo) chk(stop_halves, v[2:1]);
      chk({biphase_on, one_bit_delim}, {v[1], v[2]});
    end
    $display("Test fields done");
    for (int r = 0; r < 4; r++) begin
      wr(`SFC_OFS_CONFIG, {16'h0, r[1:0], 14'h0});
      for (int b = 0; b < 2; b++) begin
        @(posedge clk_sys);
        send_bit <= b[0];
        tx_core_out <= !b[0];
        cyc(5);
        chk(seen_bit, r == 0 ? !b[0] : (r == 2 ? 1'b1 : b[0]));
        chk(rx_core_in, r == 3 ? 1'b1 : (r == 2 ? !b[0] : b[0]));
        chk({tx_active, rx_active}, {2{r != 3}});
      end
    end
    for (int f = 0; f < 2; f++) begin
      wr(`SFC_OFS_CONFIG, {3'h0, f[0], 28'h0});
      cyc(4);
      lo = 1'b1;
      send_bit <= 1'b0;
      @(posedge clk_sys);
      send_bit <= 1'b1;
      repeat (6) begin
        cyc(1);
        lo = lo & rx_core_in;
      end
      chk(lo, f[0]);
    end
    $display("Test routing done");
    wr(`SFC_OFS_CONFIG, 32'h00000100);
    cyc(3);
    chk(tx_sync_cmd, 1'b1);
    wr(`SFC_OFS_CONFIG, 32'h00400000);
    cyc(3);
    chk(tx_sync_cmd, 1'b0);
    wr(`SFC_OFS_THR_WR, 32'h00008000);
    cyc(3);
    chk(tx_sync_cmd, 1'b1);
    wr(`SFC_OFS_IEN_SET, 32'hffffffff);
    rd(`SFC_OFS_IEN_VIEW, `SFC_IEN_MASK);
    wr(`SFC_OFS_IEN_CLR, 32'h000000ff);
    wr(`SFC_OFS_IEN_SET, 32'h0);
    wr(`SFC_OFS_IEN_CLR, 32'h0);
    rd(`SFC_OFS_IEN_VIEW, `SFC_IEN_MASK & 32'hffffff00);
    wr(`SFC_OFS_IEN_SET, 32'h00000001);
    cyc(2);
    chk(irq_enables, `SFC_IEN_MASK & 32'hffffff01);
    nrst <= 1'b0;
    cyc(2);
    nrst <= 1'b1;
    rd(`SFC_OFS_IEN_VIEW, 32'h0);
    $display("Test enables done");
    wr(`SFC_OFS_CONFIG, {28'h0, `SFC_PROTO_T0});
    cyc(3);
    pe(1'b1);
    pe(1'b1);
    wr(`SFC_OFS_CONFIG, {28'h0010000, `SFC_PROTO_T0});
    cyc(3);
    pe(1'b0);
    wr(`SFC_OFS_CONFIG, {28'h0220000, `SFC_PROTO_T0});
    cyc(3);
    pe(1'b1);
    pe(1'b1);
    pe(1'b0);
    cyc(1);
    chk(limit_hit, 1'b1);
    @(posedge clk_sys);
    limit_clr <= 1'b1;
    char_ok <= 1'b1;
    @(posedge clk_sys);
    limit_clr <= 1'b0;
    char_ok <= 1'b0;
    cyc(2);
    chk(limit_hit, 1'b0);
    pe(1'b1);
    wr(`SFC_OFS_CONFIG, {28'h0220000, `SFC_PROTO_T1});
    cyc(3);
    repeat (3) pe(1'b1);
    chk(limit_hit, 1'b0);
    $display("Test refusal done");
    test_done;
  end
endmodule
bind sfc_top sfc_chk u_chk (.*);
`default_nettype wire
